/* rtl/ams_clk_div.sv */
// Converter clock tick generator from the selected source clock
`timescale 1ns/10ps
module ams_clk_div (
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    input  wire logic       i_src_tick,
    input  wire logic [2:0] i_div_sel,
    output logic            o_phi_tick
);
    logic [3:0] cnt_ff;
    logic [3:0] div_m1;

    // Divider per select: /4,/2,/1,-,/12,/6,/3,-
    always_comb begin
        case (i_div_sel)
            3'h0:    div_m1 = 4'h3;
            3'h1:    div_m1 = 4'h1;
            3'h2:    div_m1 = 4'h0;
            3'h4:    div_m1 = 4'hB;
            3'h5:    div_m1 = 4'h5;
            3'h6:    div_m1 = 4'h2;
            default: div_m1 = 4'h0;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cnt_ff     <= 4'h0;
            o_phi_tick <= 1'b0;
        end else begin
            o_phi_tick <= 1'b0;
            if (i_src_tick) begin
                if (cnt_ff >= div_m1) begin
                    cnt_ff     <= 4'h0;
                    o_phi_tick <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 4'h1;
                end
            end
        end
    end
endmodule

/* rtl/ams_pkg.sv */
// Package: shared constants and carrier types of the converter mode sequencer
package ams_pkg;

    // ==========================================================
    // Mode encodings (upper bit, two-bit field)
    localparam logic [1:0] MODE_ONE_SHOT     = 2'h0;
    localparam logic [1:0] MODE_REPEAT       = 2'h1;
    localparam logic [1:0] MODE_SINGLE_SWEEP = 2'h2;
    localparam logic [1:0] MODE_REPEAT_SWEEP = 2'h3;

    // ==========================================================
    // Widths and reset values
    localparam int          RESULT_W      = 10;
    localparam int          NUM_RESULTS   = 8;
    localparam logic [9:0]  RESULT_RESET  = 10'h000;

    // ==========================================================
    // Timing in converter clock (phi) cycles and source clock cycles
    localparam int EXEC_CYCLES_PLAIN  = 40;
    localparam int EXEC_CYCLES_ASSIST = 42;
    localparam int GAP_CYCLES         = 1;
    localparam int END_SRC_CYCLES     = 2;
    localparam int START_SRC_EXTRA    = 1;

    // ==========================================================
    // Open-circuit assist encodings
    localparam logic [1:0] ASSIST_NONE      = 2'h0;
    localparam logic [1:0] ASSIST_PRECHARGE = 2'h1;
    localparam logic [1:0] ASSIST_DISCHARGE = 2'h2;

    // Control bits gathered as one carrier
    typedef struct packed {
        logic       mode_upper_bit;
        logic [1:0] mode_field;
        logic [2:0] channel_field;
        logic [1:0] group_select;
        logic [1:0] sweep_group;
        logic [1:0] extension_pin;
        logic       trigger_select_bit;
        logic       standby_release_bit;
        logic [1:0] open_circuit_assist;
        logic [3:0] clock_select;
    } ams_ctrl_t;

    // Request to the analog core
    typedef struct packed {
        logic       start;
        logic [1:0] group;
        logic [2:0] pin;
        logic [1:0] extension;
        logic [1:0] assist;
    } ams_conv_req_t;

endpackage

/* rtl/ams_sequencer.sv */
// Converter mode sequencer: start, trigger, pin walk, result placement, completion
`timescale 1ns/10ps
module ams_sequencer #(
    parameter int EXEC_PLAIN  = ams_pkg::EXEC_CYCLES_PLAIN,
    parameter int EXEC_ASSIST = ams_pkg::EXEC_CYCLES_ASSIST
) (
    input  wire logic                              i_mclk,
    input  wire logic                              i_reset_n,
    input  wire ams_pkg::ams_ctrl_t                i_ctrl,
    input  wire logic                              i_start_wr,
    input  wire logic                              i_start_wdata,
    input  wire logic                              i_oco40m_tick,
    input  wire logic                              i_external_trigger_pin,
    input  wire logic [ams_pkg::RESULT_W-1:0]      i_conv_data,
    input  wire logic                              i_irq_clear,
    output logic                                   o_conversion_start_bit,
    output logic                                   o_busy,
    output logic                                   o_irq_request,
    output ams_pkg::ams_conv_req_t                 o_conv_req,
    output logic [ams_pkg::NUM_RESULTS*ams_pkg::RESULT_W-1:0] o_result_registers,
    output logic [7:0]                             o_result_valid
);
    // ==========================================================
    // State machine
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ARMED = 3'b001,
        ST_START = 3'b010,
        ST_EXEC  = 3'b011,
        ST_GAP   = 3'b100,
        ST_END   = 3'b101
    } ams_state_t;

    ams_state_t  state_ff;
    logic        req_ff;
    logic        start_bit_ff;
    logic [5:0]  cnt_ff;
    logic [2:0]  pin_ff;
    logic        phi_tick;
    logic        src_tick;
    logic        trig_fall;
    logic        sweep_mode;
    logic        repeat_mode;
    logic [2:0]  last_pin;
    logic [5:0]  exec_len;
    logic [5:0]  start_len;
    logic [2:0]  dest_reg;
    logic        stop_req;

    // ==========================================================
    // Clocking and trigger
    assign src_tick = i_ctrl.clock_select[3] ? i_oco40m_tick : 1'b1;

    ams_clk_div u_div (
        .i_mclk     (i_mclk),
        .i_reset_n  (i_reset_n),
        .i_src_tick (src_tick),
        .i_div_sel  (i_ctrl.clock_select[2:0]),
        .o_phi_tick (phi_tick)
    );

    ams_trig_sync u_trig (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_pin     (i_external_trigger_pin),
        .o_fall    (trig_fall)
    );

    // ==========================================================
    // Mode decode
    assign sweep_mode  = i_ctrl.mode_field[1];
    assign repeat_mode = i_ctrl.mode_field[0];
    assign last_pin    = {i_ctrl.sweep_group, 1'b1};
    assign exec_len    = (i_ctrl.open_circuit_assist != ams_pkg::ASSIST_NONE)
                       ? 6'(EXEC_ASSIST) : 6'(EXEC_PLAIN);
    assign start_len   = 6'(ams_pkg::START_SRC_EXTRA + 1);
    assign stop_req    = i_start_wr && !i_start_wdata;

    // Destination register for the pin under conversion
    function automatic logic [2:0] dest_of(input logic sweep, input logic [1:0] ext,
                                           input logic [2:0] ch, input logic [2:0] pin);
        if (sweep)
            dest_of = pin;
        else if (ext == 2'h1)
            dest_of = 3'h0;
        else if (ext == 2'h2)
            dest_of = 3'h1;
        else
            dest_of = ch;
    endfunction

    assign dest_reg = dest_of(sweep_mode, i_ctrl.extension_pin, i_ctrl.channel_field, pin_ff);

    // ==========================================================
    // Sequencing
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 6'h00;
            pin_ff   <= 3'h0;
            req_ff   <= 1'b0;
        end else if (stop_req || !i_ctrl.standby_release_bit) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 6'h00;
            req_ff   <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    pin_ff <= 3'h0;
                    cnt_ff <= 6'h00;
                    if (i_start_wr && i_start_wdata)
                        state_ff <= i_ctrl.trigger_select_bit ? ST_ARMED : ST_START;
                end
                ST_ARMED: begin
                    if (trig_fall)
                        state_ff <= ST_START;
                end
                ST_START: begin
                    // Start processing delay in source clock cycles
                    if (src_tick) begin
                        if (cnt_ff + 6'h01 >= start_len) begin
                            state_ff <= ST_EXEC;
                            cnt_ff   <= 6'h00;
                        end else begin
                            cnt_ff <= cnt_ff + 6'h01;
                        end
                    end
                end
                ST_EXEC: begin
                    req_ff <= 1'b1;
                    if (phi_tick) begin
                        if (cnt_ff + 6'h01 >= exec_len) begin
                            cnt_ff <= 6'h00;
                            req_ff <= 1'b0;
                            if ((sweep_mode && pin_ff != last_pin) || repeat_mode)
                                state_ff <= ST_GAP;
                            else
                                state_ff <= ST_END;
                        end else begin
                            cnt_ff <= cnt_ff + 6'h01;
                        end
                    end
                end
                ST_GAP: begin
                    if (phi_tick) begin
                        state_ff <= ST_EXEC;
                        if (!sweep_mode || pin_ff == last_pin)
                            pin_ff <= 3'h0;
                        else
                            pin_ff <= pin_ff + 3'h1;
                    end
                end
                ST_END: begin
                    if (src_tick) begin
                        if (cnt_ff + 6'h01 >= 6'(ams_pkg::END_SRC_CYCLES))
                            state_ff <= ST_IDLE;
                        else
                            cnt_ff <= cnt_ff + 6'h01;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Start bit as read back
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            start_bit_ff <= 1'b0;
        end else if (stop_req || !i_ctrl.standby_release_bit) begin
            start_bit_ff <= 1'b0;
        end else if (state_ff == ST_START && src_tick && cnt_ff + 6'h01 >= start_len) begin
            start_bit_ff <= 1'b1;
        end else if (state_ff == ST_ARMED) begin
            start_bit_ff <= 1'b1;
        end else if (state_ff == ST_END && src_tick
                     && cnt_ff + 6'h01 >= 6'(ams_pkg::END_SRC_CYCLES)
                     && !i_ctrl.trigger_select_bit) begin
            start_bit_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Completion request, set wins over clear
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_irq_request <= 1'b0;
        end else if (state_ff == ST_END && src_tick
                     && cnt_ff + 6'h01 >= 6'(ams_pkg::END_SRC_CYCLES)
                     && !repeat_mode && !stop_req) begin
            o_irq_request <= 1'b1;
        end else if (i_irq_clear) begin
            o_irq_request <= 1'b0;
        end
    end

    // ==========================================================
    // Result registers
    genvar gi;
    generate
        for (gi = 0; gi < ams_pkg::NUM_RESULTS; gi++) begin : g_res
            always_ff @(posedge i_mclk) begin
                if (!i_reset_n) begin
                    o_result_registers[gi*ams_pkg::RESULT_W +: ams_pkg::RESULT_W] <= ams_pkg::RESULT_RESET;
                    o_result_valid[gi] <= 1'b0;
                end else if (state_ff == ST_EXEC && phi_tick && cnt_ff + 6'h01 >= exec_len
                             && !stop_req && dest_reg == 3'(gi)) begin
                    o_result_registers[gi*ams_pkg::RESULT_W +: ams_pkg::RESULT_W] <= i_conv_data;
                    o_result_valid[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Analog core request and status
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_conv_req             <= '0;
            o_busy                 <= 1'b0;
            o_conversion_start_bit <= 1'b0;
        end else begin
            o_conv_req.start     <= req_ff;
            o_conv_req.group     <= i_ctrl.group_select;
            o_conv_req.pin       <= sweep_mode ? pin_ff : i_ctrl.channel_field;
            o_conv_req.extension <= sweep_mode ? 2'h0 : i_ctrl.extension_pin;
            o_conv_req.assist    <= i_ctrl.open_circuit_assist;
            o_busy               <= (state_ff != ST_IDLE) && (state_ff != ST_ARMED);
            o_conversion_start_bit <= start_bit_ff;
        end
    end
endmodule

/* rtl/ams_trig_sync.sv */
// Three-stage synchroniser with falling-edge detect for the trigger pin
`timescale 1ns/10ps
module ams_trig_sync (
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    input  wire logic i_pin,
    output logic      o_fall
);
    logic [2:0] sync_ff;
    logic       level_ff;

    // Stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            sync_ff  <= 3'h7;
            level_ff <= 1'b1;
            o_fall   <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[1:0], i_pin};
            o_fall  <= 1'b0;
            if (sync_ff[1] == sync_ff[2] && sync_ff[2] != level_ff) begin
                level_ff <= sync_ff[2];
                o_fall   <= ~sync_ff[2];
            end
        end
    end
endmodule

/* sim/ams_core_model.sv */
// Analog core and trigger source model for the converter sequencer
`timescale 1ns/10ps
module ams_core_model (
    input  wire logic                   i_mclk,
    input  wire ams_pkg::ams_conv_req_t i_conv_req,
    input  wire logic                   i_fire,
    output logic [9:0]                  o_conv_data,
    output logic                        o_trigger_pin
);
    logic [9:0] last_ff = 10'h000;
    logic       live_ff = 1'b0;
    logic [2:0] low_ff  = 3'h0;
    logic [2:0] spin_ff = 3'h0;
    logic [9:0] now_val;
    // Value names the pin; stale data scrambles once the hold cycle is over
    assign now_val = {3'h5, i_conv_req.group, i_conv_req.pin, i_conv_req.extension};
    assign o_conv_data = i_conv_req.start ? now_val : (live_ff ? last_ff : ~last_ff ^ {7'h00, spin_ff});
    // Shared interrupt and key inputs taken as disabled by software on these pins
    assign o_trigger_pin = (low_ff == 3'h0);
    always @(posedge i_mclk) begin
        spin_ff <= spin_ff + 3'h1;
        live_ff <= i_conv_req.start;
        if (i_conv_req.start) begin
            last_ff <= now_val;
        end
        // Low pulse of four cycles, above the two-cycle minimum
        if (i_fire) begin
            low_ff <= 3'h4;
        end else if (low_ff != 3'h0) begin
            low_ff <= low_ff - 3'h1;
        end
    end
endmodule

/* sim/ams_sequencer_bench.sv */
// Self-checking bench for the converter mode sequencer
`timescale 1ns/10ps
module ams_sequencer_bench;
    logic                   i_mclk;
    logic                   i_reset_n;
    ams_pkg::ams_ctrl_t     ctrl;
    logic                   wr_s;
    logic                   wr_d;
    logic                   irq_clr;
    logic                   fire;
    logic                   trig_pin;
    logic                   osc = 1'b0;
    logic [9:0]             cdata;
    logic                   sbit;
    logic                   busy;
    logic                   irq;
    ams_pkg::ams_conv_req_t req;
    logic [79:0]            res;
    logic [7:0]             valid;
    int                     n_mismatch;
    int                     checked;
    int                     cycles;
    ams_sequencer #(.EXEC_PLAIN(4), .EXEC_ASSIST(6)) ams_sequencer_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_ctrl(ctrl), .i_start_wr(wr_s), .i_start_wdata(wr_d), .i_oco40m_tick(osc),
        .i_external_trigger_pin(trig_pin), .i_conv_data(cdata), .i_irq_clear(irq_clr),
        .o_conversion_start_bit(sbit), .o_busy(busy), .o_irq_request(irq), .o_conv_req(req),
        .o_result_registers(res), .o_result_valid(valid));
    ams_core_model ams_core_model_i (.i_mclk(i_mclk), .i_conv_req(req), .i_fire(fire),
        .o_conv_data(cdata), .o_trigger_pin(trig_pin));
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    // Fast oscillator source at half the bench clock rate
    always @(negedge i_mclk) osc <= ~osc;
    task end_sim;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("FAIL %0t: timeout", $time);
            end_sim;
        end
    end
    task chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t: %s", $time, msg);
        end
    endtask
    task chk1(input logic got, input logic exp, input string msg);
        chk({9'h000, got}, {9'h000, exp}, msg);
    endtask
    function automatic logic [9:0] ev(input logic [1:0] g, input int p);
        return {3'h5, g, 3'(p), 2'h0};
    endfunction
    function automatic logic [9:0] rg(input int n);
        return res[n*10 +: 10];
    endfunction
    task tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task wr(input logic v);
        wr_s = 1'b1;
        wr_d = v;
        tick(1);
        wr_s = 1'b0;
    endtask
    task idle;
        tick(3);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) tick(1);
        tick(2);
    endtask
    task irqc;
        irq_clr = 1'b1;
        tick(1);
        irq_clr = 1'b0;
        tick(1);
        chk1(irq, 1'b0, "request not cleared");
    endtask
    task setc(input logic [1:0] m, input logic [2:0] ch, input logic [1:0] g, input logic [1:0] s,
              input logic [1:0] e, input logic t, input logic [1:0] a);
        ctrl.mode_field = m;
        ctrl.channel_field = ch;
        ctrl.group_select = g;
        ctrl.sweep_group = s;
        ctrl.extension_pin = e;
        ctrl.trigger_select_bit = t;
        ctrl.open_circuit_assist = a;
        tick(2);
    endtask
    // ==========================================================
    // Scenarios
    task t_one_shot;
        setc(2'h0, 3'h5, 2'h1, 2'h3, 2'h0, 1'b0, ams_pkg::ASSIST_PRECHARGE);
        wr(1'b1);
        idle;
        chk(rg(5), ev(2'h1, 5), "one-shot result");
        chk({2'h0, valid}, 10'h020, "one-shot wrote other places");
        chk1(irq, 1'b1, "no completion request");
        chk1(sbit, 1'b0, "start bit not cleared");
        irqc;
        setc(2'h0, 3'h0, 2'h0, 2'h0, 2'h2, 1'b0, ams_pkg::ASSIST_NONE);
        wr(1'b1);
        idle;
        chk({8'h00, res[11:10]}, 10'h002, "extension result place");
        chk({2'h0, valid}, 10'h022, "extension valid set");
        irqc;
        $display("test one_shot done");
    endtask
    task t_sweep;
        setc(2'h2, 3'h7, 2'h2, 2'h1, 2'h0, 1'b0, ams_pkg::ASSIST_NONE);
        wr(1'b1);
        idle;
        for (int n = 0; n < 4; n++) chk(rg(n), ev(2'h2, n), "sweep result");
        chk({2'h0, valid}, 10'h02F, "sweep length");
        chk1(irq, 1'b1, "no sweep request");
        chk1(sbit, 1'b0, "start bit not cleared");
        irqc;
        setc(2'h3, 3'h0, 2'h0, 2'h3, 2'h0, 1'b0, ams_pkg::ASSIST_NONE);
        wr(1'b1);
        tick(150);
        for (int n = 0; n < 8; n++) chk(rg(n), ev(2'h0, n), "repeat sweep result");
        chk1(busy, 1'b1, "repeat sweep stopped");
        chk1(irq, 1'b0, "request in repeat sweep");
        wr(1'b0);
        tick(3);
        chk1(busy, 1'b0, "stop ignored");
        $display("test sweep done");
    endtask
    task t_clock;
        ctrl.clock_select = 4'h8;
        setc(2'h0, 3'h3, 2'h2, 2'h0, 2'h0, 1'b0, ams_pkg::ASSIST_NONE);
        wr(1'b1);
        tick(20);
        chk1(busy, 1'b1, "slow converter clock ignored");
        idle;
        chk(rg(3), ev(2'h2, 3), "slow clock result");
        irqc;
        ctrl.clock_select = 4'h2;
        tick(2);
        $display("test clock done");
    endtask
    task t_repeat;
        setc(2'h1, 3'h2, 2'h3, 2'h0, 2'h0, 1'b0, ams_pkg::ASSIST_DISCHARGE);
        wr(1'b1);
        tick(60);
        chk(rg(2), ev(2'h3, 2), "repeat result");
        chk1(busy, 1'b1, "repeat stopped");
        chk1(irq, 1'b0, "request in repeat");
        wr(1'b0);
        tick(3);
        chk1(busy, 1'b0, "stop ignored");
        chk1(sbit, 1'b0, "start bit after stop");
        $display("test repeat done");
    endtask
    task t_ext_trig;
        setc(2'h0, 3'h6, 2'h3, 2'h0, 2'h0, 1'b1, ams_pkg::ASSIST_NONE);
        wr(1'b1);
        tick(20);
        chk(rg(6), ev(2'h0, 6), "converted before trigger");
        fire = 1'b1;
        tick(1);
        fire = 1'b0;
        for (int i = 0; i < 300 && irq !== 1'b1; i++) tick(1);
        chk(rg(6), ev(2'h3, 6), "triggered result");
        chk1(sbit, 1'b1, "start bit cleared in trigger mode");
        wr(1'b0);
        tick(2);
        irqc;
        $display("test ext_trig done");
    endtask
    task t_standby;
        setc(2'h0, 3'h1, 2'h0, 2'h0, 2'h0, 1'b0, ams_pkg::ASSIST_NONE);
        ctrl.standby_release_bit = 1'b0;
        tick(2);
        wr(1'b1);
        tick(6);
        chk1(busy, 1'b0, "converting in standby");
        chk1(valid[1], 1'b1, "extension flag lost");
        $display("test standby done");
    endtask
    initial begin
        i_reset_n = 1'b0;
        ctrl = '0;
        ctrl.standby_release_bit = 1'b1;
        ctrl.clock_select = 4'h2;
        wr_s = 1'b0;
        wr_d = 1'b0;
        irq_clr = 1'b0;
        fire = 1'b0;
        n_mismatch = 0;
        checked = 0;
        cycles = 0;
        tick(4);
        i_reset_n = 1'b1;
        tick(3);
        t_one_shot;
        t_clock;
        t_sweep;
        t_repeat;
        t_ext_trig;
        t_standby;
        end_sim;
    end
endmodule
bind ams_sequencer ams_sequencer_props #(.EXEC_PLAIN(EXEC_PLAIN), .EXEC_ASSIST(EXEC_ASSIST)) props_i (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ctrl(i_ctrl), .i_start_wr(i_start_wr),
    .i_start_wdata(i_start_wdata), .i_irq_clear(i_irq_clear), .o_conversion_start_bit(o_conversion_start_bit),
    .o_busy(o_busy), .o_irq_request(o_irq_request), .o_conv_req(o_conv_req));

/* sim/ams_sequencer_props.sv */
// Concurrent checks on the converter mode sequencer ports
`timescale 1ns/10ps
module ams_sequencer_props #(
    parameter int EXEC_PLAIN  = ams_pkg::EXEC_CYCLES_PLAIN,
    parameter int EXEC_ASSIST = ams_pkg::EXEC_CYCLES_ASSIST
) (
    input wire logic                   i_mclk,
    input wire logic                   i_reset_n,
    input wire ams_pkg::ams_ctrl_t     i_ctrl,
    input wire logic                   i_start_wr,
    input wire logic                   i_start_wdata,
    input wire logic                   i_irq_clear,
    input wire logic                   o_conversion_start_bit,
    input wire logic                   o_busy,
    input wire logic                   o_irq_request,
    input wire ams_pkg::ams_conv_req_t o_conv_req
);
    logic [2:0] last_pin_ff;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    // ==========================================================
    // Pin of the previous conversion, for the sweep order check
    always_ff @(posedge i_mclk) begin
        if ($rose(o_conv_req.start)) begin
            last_pin_ff <= o_conv_req.pin;
        end
    end
    // ==========================================================
    // Assertions and cover points
    a_stop_halts: assert property (i_start_wr && !i_start_wdata |-> ##[1:2] (!o_busy && !o_conversion_start_bit))
        else $error("stop write did not halt");
    a_standby_halts: assert property (!i_ctrl.standby_release_bit |-> ##[1:2] !o_busy)
        else $error("busy while in standby");
    a_start_delay: assert property (i_start_wr && i_start_wdata && !o_busy && !o_conversion_start_bit
        && i_ctrl.standby_release_bit && !i_ctrl.trigger_select_bit
        |=> !o_conversion_start_bit ##[1:8] o_conversion_start_bit)
        else $error("start bit timing wrong");
    a_self_clear: assert property ($fell(o_busy) && !i_ctrl.trigger_select_bit && i_ctrl.standby_release_bit
        |-> ##[0:2] !o_conversion_start_bit)
        else $error("start bit not cleared at end");
    a_irq_holds: assert property (o_irq_request && !i_irq_clear |=> o_irq_request)
        else $error("request dropped without clear");
    a_repeat_quiet: assert property (i_ctrl.mode_field[0] && $past(i_ctrl.mode_field[0]) |-> !$rose(o_irq_request))
        else $error("request raised in repeating mode");
    a_pin_bound: assert property (o_conv_req.start && i_ctrl.mode_field[1]
        |-> o_conv_req.pin <= {i_ctrl.sweep_group, 1'b1})
        else $error("sweep pin outside group");
    a_sweep_order: assert property ($rose(o_conv_req.start) && i_ctrl.mode_field[1]
        |-> o_conv_req.pin == 3'h0 || o_conv_req.pin == last_pin_ff + 3'h1)
        else $error("sweep order wrong");
    a_channel_pick: assert property (o_conv_req.start && !i_ctrl.mode_field[1] && i_ctrl.extension_pin == 2'h0
        |-> o_conv_req.pin == i_ctrl.channel_field && o_conv_req.group == i_ctrl.group_select)
        else $error("wrong single pin");
    a_assist_pass: assert property (o_conv_req.start |-> o_conv_req.assist == i_ctrl.open_circuit_assist)
        else $error("assist setting not passed");
    a_gap_restart: assert property ($fell(o_conv_req.start) && o_busy && i_ctrl.mode_field != 2'h0
        |-> ##[1:40] (o_conv_req.start || !o_busy))
        else $error("next conversion late");
    c_irq: cover property ($rose(o_irq_request));
    c_wrap: cover property ($rose(o_conv_req.start) && o_conv_req.pin == 3'h0 && last_pin_ff == 3'h7);
    c_stop: cover property (i_start_wr && !i_start_wdata && o_busy);
endmodule
